// file: snv_core.sv
// serial nvram command slave: command decode, status, array, sleep and pause
`timescale 1ns/1ps
module snv_core #(
    parameter int DEPTH = 32768,
    parameter int SLEEP_CYC = snv_pkg::SLEEP_REC_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // serial pins
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic soOe,
    // protection and pause pins
    input wire logic wpN,
    input wire logic pauseN,
    // observed state
    output logic [7:0] statusByte,
    output logic sleeping
);
    import snv_pkg::*;
    snv_pin_if pins ();
    snv_sync u_sync (
        .clock(clock),
        .reset(reset),
        .csN(csN),
        .sck(sck),
        .si(si),
        .pauseN(pauseN),
        .wpN(wpN),
        .pins(pins)
    );
    typedef struct packed {
        snv_phase_e phase;
        logic [7:0] cmd;
        logic [7:0] shiftIn;
        logic [4:0] bitCnt;
        logic [3:0] addrCnt;
        logic [ADDR_W-1:0] addr;
        logic [7:0] shiftOut;
        logic [5:0] outCnt;
        logic soBit;
        logic reading;
        logic [7:0] status;
        logic wroteCmd;
        logic sleepArm;
        logic sleep;
        logic waking;
        logic [16:0] wakeCnt;
        logic paused;
        logic [7:0] wrData;
        logic wrStrobe;
        logic [ADDR_W-1:0] wrAddr;
    } snv_core_s;
    snv_core_s st_r;
    snv_core_s st_nxt;
    logic [7:0] mem [DEPTH];
    logic [7:0] rdByte;
    logic arrProt;
    logic statWrOk;
    logic active;
    logic [7:0] inByte;
    // block protect decode by the top address bits
    always_comb begin
        unique case ({st_r.status[BP_HI_BIT], st_r.status[BP_LO_BIT]})
            2'b00: arrProt = 1'b0;
            2'b01: arrProt = (st_r.addr[ADDR_W-1:ADDR_W-2] == 2'b11);
            2'b10: arrProt = st_r.addr[ADDR_W-1];
            2'b11: arrProt = 1'b1;
        endcase
    end
    // status writes need the latch and, if protect is set, the pin high
    assign statWrOk = st_r.status[LATCH_BIT] &
        ~(st_r.status[STAT_PROT_BIT] & ~pins.wpLevel);
    assign active = ~pins.csLevel & ~st_r.sleep & ~st_r.waking;
    assign inByte = {st_r.shiftIn[6:0], pins.siLevel};
    assign rdByte = mem[st_r.addr];
    // command sequencing on filtered serial clock edges
    always_comb begin
        st_nxt = st_r;
        st_nxt.wrStrobe = 1'b0;
        st_nxt.paused = active & ~pins.pauseLevel;
        if (st_r.waking) begin
            st_nxt.wakeCnt = st_r.wakeCnt + 17'h00001;
            if (st_r.wakeCnt >= 17'(SLEEP_CYC - 1)) begin
                st_nxt.waking = 1'b0;
            end
        end
        if (st_r.sleep && pins.csFall) begin
            st_nxt.sleep = 1'b0;
            st_nxt.waking = 1'b1;
            st_nxt.wakeCnt = 17'h00000;
        end
        if (pins.csRise) begin
            // end of frame: latch clears after a recognised write
            if (st_r.wroteCmd && !st_r.paused) begin
                st_nxt.status[LATCH_BIT] = 1'b0;
            end
            if (st_r.sleepArm && !st_r.paused) begin
                st_nxt.sleep = 1'b1;
            end
            st_nxt.phase = PH_OPCODE;
            st_nxt.bitCnt = 5'h00;
            st_nxt.reading = 1'b0;
            st_nxt.wroteCmd = 1'b0;
            st_nxt.sleepArm = 1'b0;
            st_nxt.paused = 1'b0;
        end else if (active && pins.pauseLevel && !st_r.paused) begin
            if (pins.sckRise) begin
                st_nxt.sleepArm = 1'b0;
                st_nxt.shiftIn = inByte;
                st_nxt.bitCnt = st_r.bitCnt + 5'h01;
                unique case (st_r.phase)
                    PH_OPCODE: begin
                        if (st_r.bitCnt == 5'h07) begin
                            st_nxt.cmd = inByte;
                            st_nxt.bitCnt = 5'h00;
                            st_nxt.outCnt = 6'h00;
                            st_nxt.phase = PH_IGNORE;
                            unique case (inByte)
                                CMD_SET_LATCH: st_nxt.status[LATCH_BIT] = 1'b1;
                                CMD_CLR_LATCH: st_nxt.status[LATCH_BIT] = 1'b0;
                                CMD_STAT_RD: begin
                                    st_nxt.reading = 1'b1;
                                    st_nxt.shiftOut = st_r.status;
                                end
                                CMD_STAT_WR: begin
                                    st_nxt.phase = PH_DATA;
                                    st_nxt.wroteCmd = 1'b1;
                                end
                                CMD_ARR_RD, CMD_ARR_WR: begin
                                    st_nxt.phase = PH_ADDR;
                                    st_nxt.addrCnt = 4'h0;
                                    st_nxt.wroteCmd = (inByte == CMD_ARR_WR);
                                end
                                CMD_ID_RD: begin
                                    st_nxt.reading = 1'b1;
                                    st_nxt.shiftOut = DEVICE_ID[31:24];
                                end
                                CMD_SLEEP: st_nxt.sleepArm = 1'b1;
                                default: st_nxt.phase = PH_IGNORE;
                            endcase
                        end
                    end
                    PH_ADDR: begin
                        // top address bit is dropped by the shift width
                        st_nxt.addr = {st_r.addr[ADDR_W-2:0], pins.siLevel};
                        st_nxt.addrCnt = st_r.addrCnt + 4'h1;
                        st_nxt.bitCnt = 5'h00;
                        if (st_r.addrCnt == 4'hf) begin
                            if (st_r.cmd == CMD_ARR_RD) begin
                                st_nxt.phase = PH_IGNORE;
                                st_nxt.reading = 1'b1;
                                st_nxt.outCnt = 6'h00;
                            end else begin
                                st_nxt.phase = PH_DATA;
                            end
                        end
                    end
                    PH_DATA: begin
                        if (st_r.bitCnt == 5'h07) begin
                            st_nxt.bitCnt = 5'h00;
                            if (st_r.cmd == CMD_STAT_WR) begin
                                if (statWrOk) begin
                                    st_nxt.status = (inByte & STATUS_NV_MASK) |
                                        (st_r.status & ~STATUS_NV_MASK);
                                end
                                st_nxt.phase = PH_IGNORE;
                            end else begin
                                if (st_r.status[LATCH_BIT] && !arrProt) begin
                                    st_nxt.wrStrobe = 1'b1;
                                    st_nxt.wrData = inByte;
                                    st_nxt.wrAddr = st_r.addr;
                                end
                                st_nxt.addr = st_r.addr + 15'h0001;
                            end
                        end
                    end
                    PH_IGNORE: st_nxt.bitCnt = 5'h00;
                endcase
            end
            if (pins.sckFall && st_r.reading) begin
                // output moves on falling edges
                st_nxt.soBit = st_r.shiftOut[7];
                st_nxt.shiftOut = {st_r.shiftOut[6:0], 1'b0};
                st_nxt.outCnt = st_r.outCnt + 6'h01;
                if (st_r.outCnt[2:0] == 3'h7) begin
                    unique case (st_r.cmd)
                        CMD_STAT_RD: st_nxt.shiftOut = st_r.status;
                        CMD_ARR_RD: begin
                            st_nxt.addr = st_r.addr + 15'h0001;
                            st_nxt.shiftOut = mem[st_r.addr + 15'h0001];
                        end
                        default: begin
                            unique case (st_r.outCnt[5:3])
                                3'h0: st_nxt.shiftOut = DEVICE_ID[23:16];
                                3'h1: st_nxt.shiftOut = DEVICE_ID[15:8];
                                3'h2: st_nxt.shiftOut = DEVICE_ID[7:0];
                                default: st_nxt.reading = 1'b0;
                            endcase
                        end
                    endcase
                end
                if (st_r.cmd == CMD_ARR_RD && st_r.outCnt[2:0] == 3'h0) begin
                    st_nxt.soBit = rdByte[7];
                    st_nxt.shiftOut = {rdByte[6:0], 1'b0};
                end
            end
        end
    end
    // state register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.phase <= PH_OPCODE;
            st_r.status <= STATUS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end
    // array storage, written one cycle after the byte completes
    always_ff @(posedge clock) begin
        if (st_r.wrStrobe) begin
            mem[st_r.wrAddr] <= st_r.wrData;
        end
    end
    // output drive: floats when deselected, asleep or paused in a read
    assign so = st_r.soBit;
    assign soOe = active & ~st_r.paused & pins.pauseLevel & (st_r.cmd == CMD_STAT_RD ||
        st_r.cmd == CMD_ARR_RD || st_r.cmd == CMD_ID_RD) & (st_r.phase == PH_IGNORE) &
        (st_r.outCnt != 6'h00 || st_r.reading);
    assign statusByte = st_r.status;
    assign sleeping = st_r.sleep | st_r.waking;
endmodule // snv_core

// file: snv_pkg.sv
// package of constants and types for the serial nvram command slave
package snv_pkg;
    localparam logic [7:0] CMD_SET_LATCH = 8'h06;
    localparam logic [7:0] CMD_CLR_LATCH = 8'h04;
    localparam logic [7:0] CMD_STAT_RD = 8'h05;
    localparam logic [7:0] CMD_STAT_WR = 8'h01;
    localparam logic [7:0] CMD_ARR_RD = 8'h03;
    localparam logic [7:0] CMD_ARR_WR = 8'h02;
    localparam logic [7:0] CMD_ID_RD = 8'h9f;
    localparam logic [7:0] CMD_SLEEP = 8'hb9;
    localparam int ADDR_W = 15;
    localparam int STAT_PROT_BIT = 7;
    localparam int BP_HI_BIT = 3;
    localparam int BP_LO_BIT = 2;
    localparam int LATCH_BIT = 1;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] STATUS_NV_MASK = 8'hfc;
    // identifier value is arbitrary
    localparam logic [31:0] DEVICE_ID = 32'h5a01a5c3;
    localparam int CLK_MHZ = 100;
    localparam int SLEEP_REC_US = 400;
    localparam int SLEEP_REC_CYC = SLEEP_REC_US * CLK_MHZ;
    typedef enum {PH_OPCODE, PH_ADDR, PH_DATA, PH_IGNORE} snv_phase_e;
endpackage

// file: snv_pin_if.sv
// interface carrying filtered pin levels and edge pulses
`timescale 1ns/1ps
interface snv_pin_if;
    logic csLevel;
    logic csFall;
    logic csRise;
    logic sckRise;
    logic sckFall;
    logic sckLevel;
    logic siLevel;
    logic pauseLevel;
    logic wpLevel;
    modport sync (output csLevel, csFall, csRise, sckRise, sckFall, sckLevel, siLevel,
        pauseLevel, wpLevel);
    modport core (input csLevel, csFall, csRise, sckRise, sckFall, sckLevel, siLevel,
        pauseLevel, wpLevel);
endinterface

// file: snv_sync.sv
// three-flop pin synchroniser with edge detection
`timescale 1ns/1ps
module snv_sync (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // raw pins
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic pauseN,
    input wire logic wpN,
    // filtered outputs
    snv_pin_if.sync pins
);
    import snv_pkg::*;
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] lvl;
        logic [4:0] prev;
    } snv_sync_s;
    snv_sync_s st_r;
    snv_sync_s st_nxt;
    // a level counts once second and third stages agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {wpN, pauseN, si, sck, csN};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.prev = st_r.lvl;
        for (int i = 0; i < 5; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
    end
    // cs idles high, pause and wp idle high
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r <= '{s1: 5'h19, s2: 5'h19, s3: 5'h19, lvl: 5'h19, prev: 5'h19};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign pins.csLevel = st_r.lvl[0];
    assign pins.csFall = st_r.prev[0] & ~st_r.lvl[0];
    assign pins.csRise = ~st_r.prev[0] & st_r.lvl[0];
    assign pins.sckLevel = st_r.lvl[1];
    assign pins.sckRise = ~st_r.prev[1] & st_r.lvl[1];
    assign pins.sckFall = st_r.prev[1] & ~st_r.lvl[1];
    assign pins.siLevel = st_r.lvl[2];
    assign pins.pauseLevel = st_r.lvl[3];
    assign pins.wpLevel = st_r.lvl[4];
endmodule // snv_sync

// file: snv_core_assertions.sv
// assertion checker for the serial nvram command slave
`timescale 1ns/1ps
module snv_core_assertions #(
    parameter int DEPTH = 32768,
    parameter int SLEEP_CYC = 40000
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // serial pins
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic soOe,
    // protection and pause pins
    input wire logic wpN,
    input wire logic pauseN,
    // observed state
    input wire logic [7:0] statusByte,
    input wire logic sleeping
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic wakeArm_r;
    int wakeCnt_r;
    // counts cycles since a select fall woke a sleeping device
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wakeArm_r <= 1'b0;
            wakeCnt_r <= 0;
        end else begin
            wakeArm_r <= sleeping && (wakeArm_r || $fell(csN));
            wakeCnt_r <= wakeArm_r ? wakeCnt_r + 1 : 0;
        end
    end
    // output floats while deselected, asleep or paused
    a_deselect_float: assert property (csN [*6] |-> !soOe)
        else $error("serial out driven while deselected");
    a_sleep_float: assert property (sleeping |-> !soOe)
        else $error("serial out driven while asleep");
    a_pause_float: assert property ((!pauseN && !csN) [*6] |-> !soOe)
        else $error("serial out driven while paused");
    // status register guards
    a_bit_zero: assert property (statusByte[0] == 1'b0)
        else $error("status bit zero not zero");
    a_protect_hold: assert property ((statusByte[7] && !wpN) [*6] |=> $stable(statusByte[7:2]))
        else $error("protected status changed");
    a_latch_needed: assert property ($changed(statusByte[7:2]) |-> $past(statusByte[1]))
        else $error("status written without latch");
    // sleep entry and wake bound
    a_sleep_entry: assert property ($rose(sleeping) |-> csN && $past(csN, 3))
        else $error("sleep entered while selected");
    a_wake_time: assert property (wakeCnt_r <= SLEEP_CYC + 16)
        else $error("wake recovery too long");
endmodule // snv_core_assertions

bind snv_core snv_core_assertions #(.DEPTH(DEPTH), .SLEEP_CYC(SLEEP_CYC)) chk (
    .clock(clock), .reset(reset), .csN(csN), .sck(sck), .si(si), .so(so), .soOe(soOe),
    .wpN(wpN), .pauseN(pauseN), .statusByte(statusByte), .sleeping(sleeping));

// file: snv_host.sv
// serial host model driving select, serial clock and data in mode 0
`timescale 1ns/1ps
module snv_host (
    // system clock for frame alignment
    input wire logic clock,
    // serial pins
    output logic csN,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic soOe
);
    // idle levels: deselected, clock low
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // open a frame on a falling system clock edge
    task automatic start();
        @(negedge clock);
        csN = 1'b0;
        #62.5;
    endtask
    // shift n bits msb first, sample serial out at the rising clock edge
    task automatic xb(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        // serial clock edges stay clear of system clock edges
        @(negedge clock);
        #1;
        for (int i = 7; i > 7 - n; i--) begin
            si = tx[i];
            #62.5 sck = 1'b1;
            rx[i] = soOe ? so : 1'bz;
            #62.5 sck = 1'b0;
        end
        si = ~si; // released line shows no stale data
    endtask
    // close the frame and keep a deselect gap
    task automatic stop();
        @(negedge clock);
        csN = 1'b1;
        repeat (12) @(negedge clock);
    endtask
endmodule // snv_host

// file: testbench.sv
// self-checking bench for the serial nvram command slave
`timescale 1ns/1ps
module testbench;
    import snv_pkg::*;
    localparam int SLP = 50;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic wpN = 1'b1;
    logic pauseN = 1'b1;
    logic csN, sck, si, so, soOe, sleeping;
    logic [7:0] statusByte, r, a, b;
    logic [7:0] wq [0:7];
    logic [7:0] rq [0:7];
    logic [7:0] old [0:5];
    logic [15:0] lo [0:2] = '{16'h6000, 16'h4000, 16'h0000};
    int fails = 0;
    int tests_run = 0;
    int seed = 32'h4d02f75b;
    // system clock
    always #5 clock = ~clock;
    snv_core #(.DEPTH(32768), .SLEEP_CYC(SLP)) dut (.clock(clock), .reset(reset), .csN(csN),
        .sck(sck), .si(si), .so(so), .soOe(soOe), .wpN(wpN), .pauseN(pauseN),
        .statusByte(statusByte), .sleeping(sleeping));
    snv_host host (.clock(clock), .csN(csN), .sck(sck), .si(si), .so(so), .soOe(soOe));
    // compare helpers
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic complete_run();
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one frame: opcode, address for array commands, then n data bytes
    task automatic run(input logic [7:0] op, input logic [15:0] adr, input int n);
        host.start();
        host.xb(op, 8, r);
        if (op == CMD_ARR_RD || op == CMD_ARR_WR) begin
            host.xb(adr[15:8], 8, r);
            host.xb(adr[7:0], 8, r);
        end
        for (int i = 0; i < n; i++) begin
            host.xb(wq[i], 8, rq[i]);
        end
        host.stop();
    endtask
    task automatic setl();
        run(CMD_SET_LATCH, 16'h0000, 0);
    endtask
    // main sequence
    initial begin
        repeat (5) @(negedge clock);
        reset = 1'b0;
        chk8(statusByte, STATUS_RST);
        // partial code, plain and under pause, leaves latch clear
        for (int p = 0; p < 2; p++) begin
            host.start();
            host.xb(CMD_SET_LATCH, 7, r);
            @(negedge clock) pauseN = p ? 1'b0 : 1'b1;
            repeat (8) @(negedge clock);
            host.stop();
            pauseN = 1'b1;
            chk1(statusByte[LATCH_BIT], 1'b0);
        end
        setl();
        chk1(statusByte[LATCH_BIT], 1'b1);
        wq[0] = CMD_CLR_LATCH;
        run(8'h55, 16'h0000, 1);
        chk1(statusByte[LATCH_BIT], 1'b1);
        run(CMD_STAT_RD, 16'h0000, 2);
        chk8(rq[0], 8'h02);
        chk8(rq[1], 8'h02);
        run(CMD_CLR_LATCH, 16'h0000, 0);
        chk1(statusByte[LATCH_BIT], 1'b0);
        // unprotected bursts across each block boundary, the last wrapping
        for (int k = 0; k < 3; k++) begin
            wq[0] = 8'($random(seed));
            wq[1] = 8'($random(seed));
            old[2 * k] = wq[0];
            old[2 * k + 1] = wq[1];
            setl();
            run(CMD_ARR_WR, lo[k] - 16'h0001, 2);
            chk1(statusByte[LATCH_BIT], 1'b0);
            run(CMD_ARR_RD, lo[k] - 16'h0001 | 16'h8000, 2);
            chk8(rq[0], old[2 * k]);
            chk8(rq[1], old[2 * k + 1]);
        end
        // each block protect setting guards its region
        for (int k = 0; k < 3; k++) begin
            setl();
            wq[0] = {4'h0, 2'(k + 1), 2'b00};
            run(CMD_STAT_WR, 16'h0000, 1);
            chk8(statusByte, wq[0]);
            setl();
            wq[0] = 8'($random(seed));
            wq[1] = ~old[2 * k + 1];
            run(CMD_ARR_WR, lo[k] - 16'h0001, 2);
            run(CMD_ARR_RD, lo[k] - 16'h0001, 2);
            chk8(rq[0], k == 2 ? old[2 * k] : wq[0]);
            chk8(rq[1], old[2 * k + 1]);
            if (k < 2) old[2 * k] = wq[0];
        end
        // status write refused with latch clear, then accepted
        wq[0] = 8'h80;
        run(CMD_STAT_WR, 16'h0000, 1);
        chk8(statusByte, 8'h0c);
        setl();
        wq[0] = 8'h8e;
        run(CMD_STAT_WR, 16'h0000, 1);
        chk8(statusByte, 8'h8c);
        // pause in mid status read
        host.start();
        host.xb(CMD_STAT_RD, 8, r);
        host.xb(8'h00, 4, a);
        @(negedge clock) pauseN = 1'b0;
        repeat (8) @(negedge clock);
        chk1(soOe, 1'b0);
        pauseN = 1'b1; // sck low as on entry
        repeat (8) @(negedge clock);
        host.xb(8'h00, 4, b);
        host.stop();
        chk8({a[7:4], b[7:4]}, 8'h8c);
        // status read with the serial clock idling high between frames
        host.sck = 1'b1;
        host.start();
        host.sck = 1'b0;
        host.xb(CMD_STAT_RD, 8, r);
        host.xb(8'h00, 8, a);
        #20;
        host.sck = 1'b1;
        host.stop();
        host.sck = 1'b0;
        chk8(a, 8'h8c);
        // write-protect pin low with protect bit blocks status writes
        @(negedge clock) wpN = 1'b0;
        setl();
        wq[0] = 8'h00;
        run(CMD_STAT_WR, 16'h0000, 1);
        chk8(statusByte & STATUS_NV_MASK, 8'h8c);
        @(negedge clock) wpN = 1'b1;
        setl();
        run(CMD_STAT_WR, 16'h0000, 1);
        chk8(statusByte, 8'h00);
        // array write refused with latch clear
        wq[0] = ~old[0];
        run(CMD_ARR_WR, lo[0] - 16'h0001, 1);
        run(CMD_ARR_RD, lo[0] - 16'h0001, 1);
        chk8(rq[0], old[0]);
        // identifier, then last bit held
        run(CMD_ID_RD, 16'h0000, 5);
        chk8(rq[0], DEVICE_ID[31:24]);
        chk8(rq[1], DEVICE_ID[23:16]);
        chk8(rq[2], DEVICE_ID[15:8]);
        chk8(rq[3], DEVICE_ID[7:0]);
        chk8(rq[4], {8{DEVICE_ID[0]}});
        // sleep, float, and wake within the recovery bound
        run(CMD_SLEEP, 16'h0000, 0);
        chk1(sleeping, 1'b1);
        chk1(soOe, 1'b0);
        host.start();
        host.stop();
        for (int i = 0; i < SLP + 40 && sleeping !== 1'b0; i++) @(negedge clock);
        chk1(sleeping, 1'b0);
        if (sleeping !== 1'b0) complete_run();
        // a clock pulse after the sleep code cancels it
        host.start();
        host.xb(CMD_SLEEP, 8, r);
        host.xb(8'h00, 1, r);
        host.stop();
        chk1(sleeping, 1'b0);
        complete_run();
    end
endmodule // testbench
